// ===== design/tpl_core.sv
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "tpl_defines.svh"
module tpl_core (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic link_clk,
    input wire logic link_nrst,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    input wire logic tx_last,
    output logic tx_ready,
    output logic tx_serial_out,
    output logic tx_byte_boundary_out,
    input wire logic rx_serial_in,
    input wire logic rx_byte_boundary_in
);
    tpl_pkg::tpl_sys_s s_reg;
    tpl_pkg::tpl_sys_s s_next;
    tpl_pkg::tpl_lnk_s l_reg;
    tpl_pkg::tpl_lnk_s l_next;

    tpl_pkg::tpl_cfg_s cfg_rst;
    logic [2:0] sys_in;
    logic [2:0] lnk_in;
    logic [1:0] rx_pins;

    assign cfg_rst = '{en: 1'b0, addr: `TPL_RST_ADDR, ctrl: `TPL_RST_CTRL,
                       sapi_h: `TPL_RST_SAPI_H, sapi_l: `TPL_RST_SAPI_L};

    // toggles coming back from the link side
    tpl_sync #(.W(3)) u_sync_sys (
        .clk(clk),
        .nrst(nrst),
        .d({l_reg.cfg_ack, l_reg.snap_ack, l_reg.err_tgl}),
        .q(sys_in)
    );

    // toggles going to the link side
    tpl_sync #(.W(3)) u_sync_lnk (
        .clk(link_clk),
        .nrst(link_nrst),
        .d({s_reg.cfg_tgl, s_reg.snap_tgl, s_reg.inj_tgl}),
        .q(lnk_in)
    );

    // receive pins from the far end
    tpl_sync #(.W(2)) u_sync_rx (
        .clk(link_clk),
        .nrst(link_nrst),
        .d({rx_serial_in, rx_byte_boundary_in}),
        .q(rx_pins)
    );

    // system clock side: bus slave and registers
    always_comb begin
        logic [7:0] ridx;
        logic wr;
        logic wok;
        logic snap_set;
        logic snap_clr;
        logic err_clr;
        ridx = s_axi_araddr[9:2];
        wr = 1'b0;
        wok = 1'b1;
        snap_set = 1'b0;
        snap_clr = 1'b0;
        err_clr = 1'b0;
        s_next = s_reg;

        if (s_axi_awvalid && s_reg.awready) begin
            s_next.aw_got = 1'b1;
            s_next.awready = 1'b0;
            s_next.widx = s_axi_awaddr[9:2];
        end
        if (s_axi_wvalid && s_reg.wready) begin
            s_next.w_got = 1'b1;
            s_next.wready = 1'b0;
            s_next.wdata = s_axi_wdata[7:0];
            s_next.wlane0 = s_axi_wstrb[0];
        end
        if (s_reg.aw_got && s_reg.w_got) begin
            wr = s_reg.wlane0;
            s_next.aw_got = 1'b0;
            s_next.w_got = 1'b0;
            s_next.bvalid = 1'b1;
        end
        if (s_reg.bvalid && s_axi_bready) begin
            s_next.bvalid = 1'b0;
            s_next.awready = 1'b1;
            s_next.wready = 1'b1;
        end

        if (s_reg.aw_got && s_reg.w_got) begin
            if (s_reg.widx == `TPL_IDX_INJECT) begin
                if (wr && s_reg.wdata[0] && !s_reg.inject) begin
                    s_next.inj_tgl = ~s_reg.inj_tgl;
                end
                if (wr) begin
                    s_next.inject = s_reg.wdata[0];
                end
            end else if (s_reg.widx == `TPL_IDX_SNAP_REQ) begin
                if (wr && s_reg.wdata[0] && !s_reg.snap_req) begin
                    s_next.snap_tgl = ~s_reg.snap_tgl;
                end
                if (wr) begin
                    s_next.snap_req = s_reg.wdata[0];
                    snap_clr = !s_reg.wdata[0];
                end
            end else if (s_reg.widx == `TPL_IDX_ENCAP) begin
                if (wr) begin
                    s_next.cfg.en = s_reg.wdata[0];
                end
            end else if (s_reg.widx == `TPL_IDX_ADDR) begin
                if (wr) begin
                    s_next.cfg.addr = s_reg.wdata;
                end
            end else if (s_reg.widx == `TPL_IDX_CTRL) begin
                if (wr) begin
                    s_next.cfg.ctrl = s_reg.wdata;
                end
            end else if (s_reg.widx == `TPL_IDX_SAPI_H) begin
                if (wr) begin
                    s_next.cfg.sapi_h = s_reg.wdata;
                end
            end else if (s_reg.widx == `TPL_IDX_SAPI_L) begin
                if (wr) begin
                    s_next.cfg.sapi_l = s_reg.wdata;
                end
            end else if (s_reg.widx == `TPL_IDX_RX_STATUS) begin
                err_clr = wr && s_reg.wdata[0];
            end else if (s_reg.widx == `TPL_IDX_TOTAL0 ||
                         s_reg.widx == `TPL_IDX_TOTAL1 ||
                         s_reg.widx == `TPL_IDX_TOTAL2 ||
                         s_reg.widx == `TPL_IDX_TOTAL3 ||
                         s_reg.widx == `TPL_IDX_SNAP_STATE) begin
                wok = 1'b1;
            end else begin
                wok = 1'b0;
            end
            s_next.bresp = wok ? `TPL_RESP_OKAY : `TPL_RESP_SLVERR;
        end

        // snapshot word is held still by the link side once acked
        if (sys_in[1] != s_reg.snap_ack_seen) begin
            s_next.snap_ack_seen = sys_in[1];
            s_next.total = l_reg.snap;
            snap_set = s_reg.snap_req;
        end
        if (snap_set) begin
            s_next.snap_done = 1'b1;
        end else if (snap_clr) begin
            s_next.snap_done = 1'b0;
        end

        // mismatch seen on receive, sticky until written with one
        if (sys_in[0] != s_reg.err_seen) begin
            s_next.err_seen = sys_in[0];
            s_next.hdr_err = 1'b1;
        end else if (err_clr) begin
            s_next.hdr_err = 1'b0;
        end

        // config words cross only when the previous copy was acked
        if (sys_in[2] == s_reg.cfg_tgl && s_reg.cfg != s_reg.cfg_hold) begin
            s_next.cfg_hold = s_reg.cfg;
            s_next.cfg_tgl = ~s_reg.cfg_tgl;
        end

        if (s_axi_arvalid && s_reg.arready) begin
            s_next.arready = 1'b0;
            s_next.rvalid = 1'b1;
            s_next.rresp = `TPL_RESP_OKAY;
            if (s_axi_araddr[11:10] != 2'h0) begin
                s_next.rdata = 8'h00;
                s_next.rresp = `TPL_RESP_SLVERR;
            end else if (ridx == `TPL_IDX_TOTAL0) begin
                s_next.rdata = s_reg.total[7:0];
            end else if (ridx == `TPL_IDX_TOTAL1) begin
                s_next.rdata = s_reg.total[15:8];
            end else if (ridx == `TPL_IDX_TOTAL2) begin
                s_next.rdata = s_reg.total[23:16];
            end else if (ridx == `TPL_IDX_TOTAL3) begin
                s_next.rdata = s_reg.total[31:24];
            end else if (ridx == `TPL_IDX_INJECT) begin
                s_next.rdata = {7'h00, s_reg.inject};
            end else if (ridx == `TPL_IDX_SNAP_REQ) begin
                s_next.rdata = {7'h00, s_reg.snap_req};
            end else if (ridx == `TPL_IDX_SNAP_STATE) begin
                s_next.rdata = {7'h00, s_reg.snap_done};
            end else if (ridx == `TPL_IDX_ENCAP) begin
                s_next.rdata = {7'h00, s_reg.cfg.en};
            end else if (ridx == `TPL_IDX_ADDR) begin
                s_next.rdata = s_reg.cfg.addr;
            end else if (ridx == `TPL_IDX_CTRL) begin
                s_next.rdata = s_reg.cfg.ctrl;
            end else if (ridx == `TPL_IDX_SAPI_H) begin
                s_next.rdata = s_reg.cfg.sapi_h;
            end else if (ridx == `TPL_IDX_SAPI_L) begin
                s_next.rdata = s_reg.cfg.sapi_l;
            end else if (ridx == `TPL_IDX_RX_STATUS) begin
                s_next.rdata = {7'h00, s_reg.hdr_err};
            end else begin
                s_next.rdata = 8'h00;
                s_next.rresp = `TPL_RESP_SLVERR;
            end
        end
        if (s_reg.rvalid && s_axi_rready) begin
            s_next.rvalid = 1'b0;
            s_next.arready = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s_reg <= '0;
            s_reg.awready <= 1'b1;
            s_reg.wready <= 1'b1;
            s_reg.arready <= 1'b1;
            s_reg.cfg <= cfg_rst;
            s_reg.cfg_hold <= cfg_rst;
        end else begin
            s_reg <= s_next;
        end
    end

    // link clock side: framer, serialiser, counter, receive check
    always_comb begin
        logic take;
        logic inc;
        logic [7:0] rbyte;
        logic [7:0] expect_byte;
        logic want;
        take = 1'b0;
        inc = 1'b0;
        rbyte = {l_reg.rx_sh, rx_pins[1]};
        expect_byte = 8'h00;
        want = 1'b0;
        l_next = l_reg;

        if (lnk_in[2] != l_reg.cfg_ack) begin
            l_next.cfg = s_reg.cfg_hold;
            l_next.cfg_ack = lnk_in[2];
        end

        if (lnk_in[0] != l_reg.inj_seen) begin
            l_next.inj_seen = lnk_in[0];
            l_next.inj_pend = 1'b1;
        end

        l_next.bitcnt = l_reg.bitcnt + 3'h1;
        l_next.shreg = {l_reg.shreg[6:0], 1'b0};
        if (l_reg.bitcnt == 3'h7) begin
            take = tx_valid && l_reg.tx_ready;
            case (l_reg.state)
                tpl_pkg::tx_idle: begin
                    // wrap frame in header when enabled
                    if (l_reg.cfg.en && tx_valid) begin
                        l_next.state = tpl_pkg::tx_hdr;
                        l_next.hdr_idx = 2'h0;
                        l_next.shreg = l_reg.cfg.addr;
                    end else if (take) begin
                        // plain framing only when not encapsulating
                        l_next.shreg = tx_data;
                        inc = 1'b1;
                        l_next.state = tx_last ? tpl_pkg::tx_close
                                               : tpl_pkg::tx_pay;
                    end else begin
                        l_next.shreg = `TPL_FLAG;
                    end
                end
                tpl_pkg::tx_hdr: begin
                    l_next.hdr_idx = l_reg.hdr_idx + 2'h1;
                    if (l_reg.hdr_idx == 2'h0) begin
                        l_next.shreg = l_reg.cfg.ctrl;
                    end else if (l_reg.hdr_idx == 2'h1) begin
                        l_next.shreg = l_reg.cfg.sapi_h;
                    end else if (l_reg.hdr_idx == 2'h2) begin
                        l_next.shreg = l_reg.cfg.sapi_l;
                    end else if (take) begin
                        l_next.shreg = tx_data;
                        inc = 1'b1;
                        l_next.state = tx_last ? tpl_pkg::tx_close
                                               : tpl_pkg::tx_pay;
                    end else begin
                        l_next.shreg = `TPL_FLAG;
                        l_next.state = tpl_pkg::tx_idle;
                    end
                end
                tpl_pkg::tx_pay: begin
                    if (take) begin
                        l_next.shreg = tx_data;
                        inc = 1'b1;
                        l_next.state = tx_last ? tpl_pkg::tx_close
                                               : tpl_pkg::tx_pay;
                    end else begin
                        // underrun aborts the frame with a flag
                        l_next.shreg = `TPL_FLAG;
                        l_next.state = tpl_pkg::tx_idle;
                    end
                end
                default: begin
                    l_next.shreg = `TPL_FLAG;
                    l_next.state = tpl_pkg::tx_idle;
                end
            endcase
        end

        want = (l_next.state == tpl_pkg::tx_pay) ||
               (l_next.state == tpl_pkg::tx_idle && !l_next.cfg.en) ||
               (l_next.state == tpl_pkg::tx_hdr && l_next.hdr_idx == 2'h3);
        l_next.tx_ready = want && (l_next.bitcnt == 3'h7);

        l_next.txd = l_next.shreg[7];
        if (l_reg.inj_pend) begin
            l_next.txd = ~l_next.shreg[7];
            l_next.inj_pend = (lnk_in[0] != l_reg.inj_seen);
        end
        // mark first bit of each transmitted byte
        l_next.txb = (l_next.bitcnt == 3'h0);

        // count packet bytes; restart to 0 or 1
        l_next.cnt = l_reg.cnt + {31'h0, inc};
        if (lnk_in[1] != l_reg.snap_ack) begin
            l_next.snap = l_reg.cnt;
            l_next.cnt = {31'h0, inc};
            l_next.snap_ack = lnk_in[1];
        end

        // far end marks receive byte start
        if (rx_pins[0]) begin
            l_next.rx_sh = {6'h00, rx_pins[1]};
            l_next.rx_cnt = 3'h1;
        end else begin
            l_next.rx_sh = {l_reg.rx_sh[5:0], rx_pins[1]};
            l_next.rx_cnt = l_reg.rx_cnt + 3'h1;
            if (l_reg.rx_cnt == 3'h7 && l_reg.cfg.en) begin
                case (l_reg.rx_idx)
                    3'h1: expect_byte = l_reg.cfg.addr;
                    3'h2: expect_byte = l_reg.cfg.ctrl;
                    3'h3: expect_byte = l_reg.cfg.sapi_h;
                    default: expect_byte = l_reg.cfg.sapi_l;
                endcase
                if (rbyte == `TPL_FLAG) begin
                    l_next.rx_idx = 3'h1;
                end else if (l_reg.rx_idx != 3'h0) begin
                    if (rbyte != expect_byte) begin
                        l_next.err_tgl = ~l_reg.err_tgl;
                        l_next.rx_idx = 3'h0;
                    end else if (l_reg.rx_idx == 3'h4) begin
                        l_next.rx_idx = 3'h0;
                    end else begin
                        l_next.rx_idx = l_reg.rx_idx + 3'h1;
                    end
                end
            end
        end
    end

    always_ff @(posedge link_clk) begin
        if (!link_nrst) begin
            l_reg <= '0;
            l_reg.cfg <= cfg_rst;
            l_reg.state <= tpl_pkg::tx_idle;
            l_reg.shreg <= `TPL_FLAG;
            l_reg.txb <= 1'b1;
        end else begin
            l_reg <= l_next;
        end
    end

    assign s_axi_awready = s_reg.awready;
    assign s_axi_wready = s_reg.wready;
    assign s_axi_bvalid = s_reg.bvalid;
    assign s_axi_bresp = s_reg.bresp;
    assign s_axi_arready = s_reg.arready;
    assign s_axi_rvalid = s_reg.rvalid;
    assign s_axi_rresp = s_reg.rresp;
    assign s_axi_rdata = {24'h000000, s_reg.rdata};
    assign tx_ready = l_reg.tx_ready;
    assign tx_serial_out = l_reg.txd;
    assign tx_byte_boundary_out = l_reg.txb;
endmodule // tpl_core
`default_nettype wire

// ===== design/tpl_defines.svh
`ifndef TPL_DEFINES_SVH
`define TPL_DEFINES_SVH
// Summary of operation
// - keep a 32-bit total of packet bytes sent; upper bytes readable
// - rising edge of the inject bit corrupts exactly one transmitted bit
// - rising edge of snapshot request captures counters, then restarts them
// - done flag set when snapshot ends, cleared when request goes back to 0
// - encapsulation enable wraps transmit frames and decodes receive frames
// - when encapsulating, received header bytes are checked against config
// - far end marks receive byte starts; device marks transmit byte starts
// - in encapsulation mode transmit frames are still bounded by 0x7E flags
// - programmable address byte, sent and checked, resets to 0x04
// - programmable control byte, sent and checked, resets to 0x03
// - programmable upper SAPI byte, sent and checked, resets to 0xFE
// - programmable lower SAPI byte, sent and checked, resets to 0x01

// register indices; byte address is four times the index
`define TPL_IDX_TOTAL0 8'hD0
`define TPL_IDX_TOTAL1 8'hD1
`define TPL_IDX_TOTAL2 8'hD2
`define TPL_IDX_TOTAL3 8'hD3
`define TPL_IDX_INJECT 8'hD4
`define TPL_IDX_SNAP_REQ 8'hD6
`define TPL_IDX_SNAP_STATE 8'hD7
`define TPL_IDX_ENCAP 8'hD8
`define TPL_IDX_ADDR 8'hD9
`define TPL_IDX_CTRL 8'hDA
`define TPL_IDX_SAPI_H 8'hDB
`define TPL_IDX_SAPI_L 8'hDC
`define TPL_IDX_RX_STATUS 8'hDE

`define TPL_RST_ADDR 8'h04
`define TPL_RST_CTRL 8'h03
`define TPL_RST_SAPI_H 8'hFE
`define TPL_RST_SAPI_L 8'h01
`define TPL_FLAG 8'h7E

`define TPL_RESP_OKAY 2'h0
`define TPL_RESP_SLVERR 2'h2
`endif

// ===== design/tpl_pkg.sv
package tpl_pkg;
    typedef enum logic [1:0] {
        tx_idle,
        tx_hdr,
        tx_pay,
        tx_close
    } tpl_tx_e;

    typedef struct packed {
        logic en;
        logic [7:0] addr;
        logic [7:0] ctrl;
        logic [7:0] sapi_h;
        logic [7:0] sapi_l;
    } tpl_cfg_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic aw_got;
        logic w_got;
        logic [7:0] widx;
        logic [7:0] wdata;
        logic wlane0;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
        logic inject;
        logic snap_req;
        logic snap_done;
        logic [31:0] total;
        logic hdr_err;
        tpl_cfg_s cfg;
        tpl_cfg_s cfg_hold;
        logic cfg_tgl;
        logic snap_tgl;
        logic inj_tgl;
        logic snap_ack_seen;
        logic err_seen;
    } tpl_sys_s;

    typedef struct packed {
        tpl_cfg_s cfg;
        logic cfg_ack;
        logic snap_ack;
        logic inj_seen;
        logic inj_pend;
        logic [31:0] cnt;
        logic [31:0] snap;
        tpl_tx_e state;
        logic [1:0] hdr_idx;
        logic [7:0] shreg;
        logic [2:0] bitcnt;
        logic txd;
        logic txb;
        logic tx_ready;
        logic [6:0] rx_sh;
        logic [2:0] rx_cnt;
        logic [2:0] rx_idx;
        logic err_tgl;
    } tpl_lnk_s;
endpackage

// ===== design/tpl_sync.sv
`timescale 1ns/1ps
`default_nettype none
module tpl_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] ff1;
        logic [W-1:0] ff2;
    } tpl_sync_s;

    tpl_sync_s s_reg;
    tpl_sync_s s_next;

    always_comb begin
        s_next.ff1 = d;
        s_next.ff2 = s_reg.ff1;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign q = s_reg.ff2;
endmodule // tpl_sync
`default_nettype wire

// ===== verif/tpl_core_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module tpl_core_monitor (
    input wire logic clk,
    input wire logic nrst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic link_clk,
    input wire logic link_nrst,
    input wire logic tx_ready,
    input wire logic tx_byte_boundary_out
);
    property p_rd_lat;
        @(posedge clk) disable iff (!nrst)
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
    property p_r_once;
        @(posedge clk) disable iff (!nrst)
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    a_r_once: assert property (p_r_once) else $error("read answered twice");
    property p_b_once;
        @(posedge clk) disable iff (!nrst)
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    a_b_once: assert property (p_b_once) else $error("write answered twice");
    property p_ar_busy;
        @(posedge clk) disable iff (!nrst) s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_ar_busy: assert property (p_ar_busy) else $error("read taken early");
    property p_aw_busy;
        @(posedge clk) disable iff (!nrst)
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_aw_busy: assert property (p_aw_busy) else $error("write taken early");
    property p_b_lat;
        @(posedge clk) disable iff (!nrst) s_axi_awvalid && s_axi_awready
            && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid;
    endproperty
    a_b_lat: assert property (p_b_lat) else $error("write answer late");
    property p_bnd_next;
        @(posedge link_clk) disable iff (!link_nrst)
        tx_ready |=> tx_byte_boundary_out;
    endproperty
    a_bnd_next: assert property (p_bnd_next) else $error("no start");
    // rose only: boundary is stuck high through link reset
    property p_bnd_per;
        @(posedge link_clk) disable iff (!link_nrst) $rose(tx_byte_boundary_out)
            |=> !tx_byte_boundary_out [*7] ##1 tx_byte_boundary_out;
    endproperty
    a_bnd_per: assert property (p_bnd_per) else $error("byte period");
    c_wr: cover property (@(posedge clk) s_axi_awvalid && s_axi_awready);
    c_rd: cover property (@(posedge clk) s_axi_arvalid && s_axi_arready);
    c_txr: cover property (@(posedge link_clk) tx_ready);
endmodule // tpl_core_monitor

bind tpl_core tpl_core_monitor mon (.clk, .nrst, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .link_clk,
    .link_nrst, .tx_ready, .tx_byte_boundary_out);
`default_nettype wire

// ===== verif/tpl_far_end.sv
`timescale 1ns/1ps
`default_nettype none
module tpl_far_end (
    input wire logic link_clk,
    input wire logic tx_serial_out,
    input wire logic tx_byte_boundary_out,
    output logic rx_serial_in,
    output logic rx_byte_boundary_in
);
    logic [7:0] got[$];
    logic [7:0] snd[$];
    logic [7:0] sh = 8'h00;
    logic [7:0] cur = 8'h7E;
    int n = 0;
    int k = 0;
    initial begin
        rx_serial_in = 1'h0;
        rx_byte_boundary_in = 1'h0;
    end
    // bytes framed by the device marker
    always @(posedge link_clk) begin
        n = tx_byte_boundary_out ? 1 : n + 1;
        sh = {sh[6:0], tx_serial_out};
        if (n == 8) got.push_back(sh);
    end
    // mark each sent byte start; flags fill the line when idle
    always @(posedge link_clk) begin
        if (k == 0) cur = snd.size() > 0 ? snd.pop_front() : 8'h7E;
        rx_byte_boundary_in <= (k == 0);
        rx_serial_in <= cur[7 - k];
        k = (k + 1) % 8;
    end
endmodule // tpl_far_end
`default_nettype wire

// ===== verif/tx_pmon_and_laps_encap_config_test.sv
`timescale 1ns/1ps
`default_nettype none
module tx_pmon_and_laps_encap_config_test;
    logic clk = '0, nrst = '0, link_clk = '0, link_nrst = '0;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_arvalid = '0;
    logic s_axi_bready = 1'h1, s_axi_rready = 1'h1, tx_valid = '0, tx_last = '0;
    logic [7:0] tx_data = '0;
    wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire logic s_axi_rvalid, tx_ready, tx_serial_out, tx_byte_boundary_out;
    wire logic rx_serial_in, rx_byte_boundary_in;
    wire logic [1:0] s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    logic [7:0] mdl [8'hD0:8'hDE] = '{default: 8'h00};
    logic [31:0] d;
    logic [1:0] r;
    int seed = 66529, mismatches = 0, checks = 0, tot = 0, last = 0, n;
    always #25 clk = ~clk;
    always #24 link_clk = ~link_clk;
    tpl_core dut (.clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .link_clk, .link_nrst, .tx_data, .tx_valid, .tx_last,
        .tx_ready, .tx_serial_out, .tx_byte_boundary_out, .rx_serial_in,
        .rx_byte_boundary_in);
    tpl_far_end far (.link_clk, .tx_serial_out, .tx_byte_boundary_out,
        .rx_serial_in, .rx_byte_boundary_in);
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        s_axi_awaddr <= {2'h0, a, 2'h0};
        s_axi_wdata <= {24'h0, v};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        r = s_axi_bresp;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        s_axi_araddr <= {2'h0, a, 2'h0};
        s_axi_arvalid <= 1'h1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask
    task automatic frame(input logic en);
        logic [7:0] e[$];
        int p = 0;
        n = 3 + $unsigned($random(seed)) % 6;
        if (en) e = '{mdl[8'hD9], mdl[8'hDA], mdl[8'hDB], mdl[8'hDC]};
        far.got.delete();
        @(posedge link_clk);
        for (int i = 0; i < n; i++) begin
            e.push_back(8'($random(seed)) | 8'h01);
            tx_data <= e[e.size() - 1];
            tx_valid <= 1'h1;
            tx_last <= (i == n - 1);
            do @(posedge link_clk); while (tx_ready !== 1'h1);
        end
        tx_valid <= 1'h0;
        tx_last <= 1'h0;
        e.push_back(8'h7E);
        tot += n;
        repeat (8 * n + 80) @(posedge link_clk);
        while (far.got[p] === 8'h7E) p++;
        foreach (e[j]) chk(32'(far.got[p + j]), 32'(e[j]));
    endtask
    task automatic totals(input int v);
        for (int i = 0; i < 4; i++) begin
            rd(8'hD0 + 8'(i));
            chk(d, 32'(8'(v >> (8 * i))));
        end
    endtask
    task automatic snap;
        int t = 0;
        wr(8'hD6, 8'h01);
        do begin
            rd(8'hD7);
            t++;
        end while (d !== 32'h1 && t < 20);
        chk(d, 32'h1);
        totals(tot);
        last = tot;
        tot = 0;
        wr(8'hD6, 8'h00);
        rd(8'hD7);
        chk(d, 32'h0);
    endtask
    task automatic inj(input logic [7:0] v, input int want);
        int p = 0;
        wr(8'hD4, v);
        wr(8'hD4, 8'h01);
        repeat (300) @(posedge link_clk);
        foreach (far.got[i]) p += int'(far.got[i] !== 8'h7E);
        chk(32'(p), 32'(want));
    endtask
    task automatic rxh(input logic [7:0] a, input logic [31:0] want);
        wr(8'hDE, 8'h01);
        far.snd = '{8'h7E, a, mdl[8'hDA], mdl[8'hDB], mdl[8'hDC], 8'h55, 8'h7E};
        repeat (120) @(posedge link_clk);
        rd(8'hDE);
        chk(d, want);
    endtask
    initial begin
        repeat (6) @(posedge clk);
        nrst <= 1'h1;
        link_nrst <= 1'h1;
        mdl[8'hD9] = 8'h04;
        mdl[8'hDA] = 8'h03;
        mdl[8'hDB] = 8'hFE;
        mdl[8'hDC] = 8'h01;
        foreach (mdl[a]) begin
            rd(8'(a));
            chk(d, 32'(mdl[a]));
            chk(32'(r), (a == 8'hD5 || a == 8'hDD) ? 32'h2 : 32'h0);
        end
        wr(8'hD3, 8'hFF);
        chk(32'(r), 32'h0);
        wr(8'hD5, 8'hFF);
        chk(32'(r), 32'h2);
        for (int a = 8'hD9; a <= 8'hDC; a++) begin
            mdl[a] = 8'($random(seed)) | 8'h01;
            wr(8'(a), mdl[a]);
            rd(8'(a));
            chk(d, 32'(mdl[a]));
        end
        wr(8'hD8, 8'h01);
        repeat (20) @(posedge clk);
        frame(1'h1);
        rxh(mdl[8'hD9], 32'h0);
        rxh(mdl[8'hD9] ^ 8'h80, 32'h1);
        rxh(mdl[8'hD9], 32'h0);
        wr(8'hD8, 8'h00);
        repeat (20) @(posedge clk);
        frame(1'h0);
        snap();
        frame(1'h0);
        totals(last);
        snap();
        far.got.delete();
        inj(8'h00, 1);
        inj(8'h01, 1);
        inj(8'h00, 2);
        print_verdict();
    end
    initial begin
        #2000000;
        mismatches++;
        print_verdict();
    end
endmodule // tx_pmon_and_laps_encap_config_test
`default_nettype wire
